// File: tb_top.sv
// Purpose: self-checking bench for the 16-bit timer core
// Assumes: cpu model on the avalon side, bench drives pin and strobe
// Notes:   read results checked from a queue of expected bytes
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tmr_pkg::*;
  logic        clk, rst_n, go, wr, be, ext_pin, cap_stb;
  logic [5:0]  adr, avs_adr;
  logic [7:0]  dat, rd_data;
  logic [31:0] wdata, rdata;
  logic [3:0]  avs_be;
  logic        rd, wt_s, wa, done, rd_valid;
  logic [15:0] cnt, cmp_a, cmp_b, cmp_c, cap, v;
  logic [15:0] tt [5];
  logic [3:0]  mt [5];
  logic        top_hit, bot_hit, max_hit, ovf;
  logic [15:0] expq [$];
  int          num_errors, n_checks, r;
  int          seed = 81461;

  tmr_counter16 dut_u (.clk_sys_i(clk), .rst_n_i(rst_n),
    .avs_address_i(avs_adr), .avs_read_i(rd), .avs_write_i(wa),
    .avs_writedata_i(wdata), .avs_byteenable_i(avs_be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt_s),
    .ext_clk_pin_i(ext_pin), .capture_strobe_i(cap_stb),
    .count_value_o(cnt), .compare_a_o(cmp_a), .compare_b_o(cmp_b),
    .compare_c_o(cmp_c), .capture_value_o(cap), .top_hit_o(top_hit),
    .bottom_hit_o(bot_hit), .max_hit_o(max_hit), .overflow_flag_o(ovf));
  tmr_cpu_model cpu_u (.clk_sys_i(clk), .rst_n_i(rst_n), .go_i(go),
    .wr_i(wr), .be_i(be), .adr_i(adr), .dat_i(dat), .rdata_i(rdata),
    .wait_i(wt_s), .read_o(rd), .write_o(wa), .adr_o(avs_adr),
    .wdata_o(wdata), .be_o(avs_be), .done_o(done),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  task complete_run;
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d,
           input logic b);
    int i;
    @(posedge clk);
    go <= 1'b1; wr <= w; adr <= a; dat <= d; be <= b;
    @(posedge clk);
    go <= 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (i >= 50) num_errors++;
  endtask
  task wr8(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b1);
  endtask
  task rd8(input logic [5:0] a, input logic [7:0] e);
    expq.push_back({8'h00, e});
    acc(1'b0, a, 8'h00, 1'b1);
  endtask
  task wr16(input logic [5:0] al, input logic [5:0] ah,
            input logic [15:0] d);
    wr8(ah, d[15:8]);
    wr8(al, d[7:0]);
  endtask
  task rd16(input logic [5:0] al, input logic [5:0] ah,
            input logic [15:0] e);
    rd8(al, e[7:0]);
    rd8(ah, e[15:8]);
  endtask
  task mode(input logic [3:0] m, input logic [2:0] cs);
    wr8(OFS_CTRL_A, {6'h00, m[1:0]});
    wr8(OFS_CTRL_B, {3'h0, m[3:2], cs});
  endtask
  // s: 0 top, 1 bottom, 2 max, other: count equals val
  task wt(input int s, input int lim, input logic [15:0] val);
    int i;
    logic h;
    i = 0;
    h = 1'b0;
    while (h !== 1'b1 && i < lim) begin
      @(negedge clk);
      h = (s == 0) ? top_hit : (s == 1) ? bot_hit :
          (s == 2) ? max_hit : (cnt === val);
      i++;
    end
    chk({15'h0, h}, 16'h0001);
  endtask

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) chk({8'h00, rd_data}, 16'hffff);
      else chk({8'h00, rd_data}, expq.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(40000 * 50);
    num_errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0; go = 1'b0; wr = 1'b0; be = 1'b0; adr = 6'h00;
    dat = 8'h00; ext_pin = 1'b0; cap_stb = 1'b0;
    tt = '{TOP_8, TOP_9, TOP_10, 16'ha511, 16'h0050};
    mt = '{WGM_FAST8, WGM_FAST9, WGM_FAST10, WGM_FAST_OCR, WGM_FAST_ICR};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({15'h0, bot_hit}, 16'h0001);
    rd8(OFS_CTRL_B, 8'h00);
    rd8(OFS_FLAGS, 8'h00);
    wr8(6'h3c, 8'h5a);
    rd8(6'h3c, 8'h00);
    acc(1'b1, OFS_CTRL_A, 8'h03, 1'b0);
    rd8(OFS_CTRL_A, 8'h00);
    // random values with the clock stopped
    repeat (4) begin
      r = $random(seed);
      v = r[15:0];
      wr16(OFS_CNT_L, OFS_CNT_H, v);
      chk(cnt, v);
      rd16(OFS_CNT_L, OFS_CNT_H, v);
    end
    repeat (20) @(posedge clk);
    chk(cnt, v);
    wr8(OFS_CMP_H[0], 8'ha5);
    wr8(OFS_CMP_L[0], 8'h11);
    wr8(OFS_CMP_L[1], 8'h22);
    wr8(OFS_CMP_L[2], 8'h33);
    chk(cmp_a, 16'ha511);
    chk(cmp_b, 16'ha522);
    chk(cmp_c, 16'ha533);
    wr8(OFS_CNT_H, 8'h3c);
    wr8(OFS_CMP_L[1], 8'h44);
    chk(cmp_b, 16'h3c44);
    chk(cnt, v);
    rd8(OFS_CNT_L, v[7:0]);
    rd8(OFS_CMP_H[1], 8'h3c);
    rd8(OFS_CMP_H[0], 8'ha5);
    rd8(OFS_CNT_H, v[15:8]);
    wr16(OFS_CAP_L, OFS_CAP_H, 16'h0040);
    chk(cap, 16'h0000);
    @(posedge clk) cap_stb <= 1'b1;
    @(posedge clk) cap_stb <= 1'b0;
    repeat (3) @(negedge clk);
    chk(cap, v);
    rd16(OFS_CAP_L, OFS_CAP_H, v);
    // fast modes: reach top, wrap to bottom, flag overflow
    for (int k = 0; k < 5; k++) begin
      mode(mt[k], CS_STOP);
      if (k == 4) begin
        wr16(OFS_CAP_L, OFS_CAP_H, 16'h0050);
        chk(cap, 16'h0050);
      end
      wr16(OFS_CNT_L, OFS_CNT_H, tt[k] - 16'h0002);
      mode(mt[k], CS_DIV8);
      wt(0, 60, 16'h0);
      chk(cnt, tt[k]);
      wt(1, 40, 16'h0);
      chk({15'h0, ovf}, 16'h0001);
      wr8(OFS_FLAGS, 8'h1f);
      chk({15'h0, ovf}, 16'h0000);
    end
    mode(WGM_NORMAL, CS_STOP);
    wr16(OFS_CNT_L, OFS_CNT_H, 16'hfffe);
    mode(WGM_NORMAL, CS_DIV8);
    wt(2, 40, 16'h0);
    chk(cnt, VAL_MAX);
    wt(1, 40, 16'h0);
    rd8(OFS_FLAGS, 8'h01);
    wr8(OFS_FLAGS, 8'h01);
    rd8(OFS_FLAGS, 8'h00);
    // compare A as top clears the count, no overflow below max
    mode(WGM_CTC_OCR, CS_STOP);
    wr16(OFS_CNT_L, OFS_CNT_H, 16'ha50f);
    mode(WGM_CTC_OCR, CS_DIV8);
    wt(0, 60, 16'h0);
    chk(cnt, 16'ha511);
    wt(1, 40, 16'h0);
    chk({15'h0, ovf}, 16'h0000);
    // dual slope turns down after top
    mode(WGM_PC8, CS_STOP);
    wr16(OFS_CNT_L, OFS_CNT_H, 16'h00fd);
    mode(WGM_PC8, CS_DIV8);
    wt(0, 60, 16'h0);
    wt(4, 60, 16'h00fe);
    mode(WGM_NORMAL, CS_SYS);
    wr16(OFS_CNT_L, OFS_CNT_H, 16'h1234);
    chk({15'h0, (cnt - 16'h1234) < 16'h0004}, 16'h0001);
    mode(WGM_NORMAL, CS_STOP);
    wr16(OFS_CNT_L, OFS_CNT_H, 16'h0100);
    // pin edges: rising first, then falling
    for (int e = 0; e < 2; e++) begin
      mode(WGM_NORMAL, e ? CS_EXT_FALL : CS_EXT_RISE);
      repeat (4) begin
        @(posedge clk) ext_pin <= 1'b1;
        repeat (6) @(posedge clk);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk);
      end
      repeat (8) @(negedge clk);
      chk(cnt, 16'h0104 + 16'(4 * e));
    end
    // slow rates: four or five ticks in four periods, phase unknown
    for (int j = 0; j < 3; j++) begin
      mode(WGM_NORMAL, CS_STOP);
      wr16(OFS_CNT_L, OFS_CNT_H, 16'h0000);
      mode(WGM_NORMAL, CS_DIV64 + 3'(j));
      repeat (256 << (2 * j)) @(posedge clk);
      mode(WGM_NORMAL, CS_STOP);
      chk({15'h0, cnt == 16'h0004 || cnt == 16'h0005}, 16'h0001);
    end
    repeat (2) @(posedge clk);
    chk(16'(expq.size()), 16'h0000);
    complete_run();
  end
endmodule

// File: tmr_counter16.sv
// Purpose: 16-bit up/down timer/counter with shared high-byte latch
// Assumes: avalon-mm slave, one wait state per access
// Notes:   waveform outputs and compare double buffering live elsewhere
// What this block does
// - flag bottom whenever the counter value becomes zero
// - flag maximum whenever the counter value becomes all ones
// - mode picks top: fixed 8/9/10-bit value, all ones, compare A or capture
// - one 8-bit high-byte latch shared by all 16-bit registers
// - low-byte write loads low byte plus latch in one cycle
// - counter and capture low-byte reads copy matching high byte into latch same cycle
// - compare high-byte reads return directly, latch untouched
// - counter high-byte location reaches only the latch
// - counter is 16-bit up/down, seen as two byte locations
// - each tick clears, increments or decrements per mode
// - 3-bit clock select, zero stops the timer
// - counter readable and writable with or without ticks
// - software counter write beats clear and count
// - 4-bit mode field split over control A and B
// - overflow flag set at mode-defined point
// - top and bottom indications driven to rest of timer
// - capture register writable only in capture-top modes
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
module tmr_counter16 (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic [tmr_pkg::AW-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  ext_clk_pin_i,
  input  wire logic                  capture_strobe_i,
  output logic [15:0]                count_value_o,
  output logic [15:0]                compare_a_o,
  output logic [15:0]                compare_b_o,
  output logic [15:0]                compare_c_o,
  output logic [15:0]                capture_value_o,
  output logic                       top_hit_o,
  output logic                       bottom_hit_o,
  output logic                       max_hit_o,
  output logic                       overflow_flag_o
);
  import tmr_pkg::*;

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [7:0]  ctrl_a_r;
  logic [7:0]  ctrl_b_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        dir_up_r;
  logic        dir_nxt;
  logic [15:0] cmp_r [3];
  logic [15:0] cap_r;
  logic [7:0]  temp_r;
  logic [4:0]  flags_r;
  logic [4:0]  flags_set;
  logic [4:0]  flags_nxt;
  logic        ovf_ev;
  logic        tick;
  logic        go;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [3:0]  wgm;
  logic [2:0]  cs;
  logic [15:0] top_val;
  tmr_kind_t   kind;

  // reset enters asynchronously, leaves synchronously
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync_r <= 2'b00;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // one request is acted on at the edge that drops waitrequest
  assign go    = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign wr_go = go & avs_write_i & avs_byteenable_i[0];
  assign rd_go = go & avs_read_i;
  assign wbyte = avs_writedata_i[7:0];

  function automatic logic wr_at(input logic [5:0] ofs);
    return wr_go && (avs_address_i == ofs);
  endfunction

  function automatic logic rd_at(input logic [5:0] ofs);
    return rd_go && (avs_address_i == ofs);
  endfunction

  function automatic logic icr_is_top(input logic [3:0] m);
    return (m == WGM_PFC_ICR) || (m == WGM_PC_ICR) ||
           (m == WGM_CTC_ICR) || (m == WGM_FAST_ICR);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] ocra,
                                         input logic [15:0] icr);
    unique case (m)
      WGM_PC8, WGM_FAST8:   return TOP_8;
      WGM_PC9, WGM_FAST9:   return TOP_9;
      WGM_PC10, WGM_FAST10: return TOP_10;
      WGM_CTC_OCR, WGM_PFC_OCR, WGM_PC_OCR, WGM_FAST_OCR: return ocra;
      WGM_PFC_ICR, WGM_PC_ICR, WGM_CTC_ICR, WGM_FAST_ICR: return icr;
      default:              return VAL_MAX;
    endcase
  endfunction

  function automatic tmr_kind_t kind_of(input logic [3:0] m);
    unique case (m)
      WGM_FAST8, WGM_FAST9, WGM_FAST10,
      WGM_FAST_ICR, WGM_FAST_OCR:        return KIND_FAST;
      WGM_PC8, WGM_PC9, WGM_PC10, WGM_PFC_ICR,
      WGM_PFC_OCR, WGM_PC_ICR, WGM_PC_OCR: return KIND_DUAL;
      default:                           return KIND_SINGLE;
    endcase
  endfunction

  assign wgm = {ctrl_b_r[CTB_WGM_LSB +: 2],
                ctrl_a_r[CTA_WGM_LSB +: 2]};
  assign cs      = ctrl_b_r[CTB_CS_LSB +: CS_W];
  assign top_val = top_of(wgm, cmp_r[0], cap_r);
  assign kind    = kind_of(wgm);

  tmr_tick_gen u_tick (
    .clk_sys_i             (clk_sys_i),
    .rst_n_i               (rst_n),
    .clock_source_select_i (cs),
    .ext_clk_pin_i         (ext_clk_pin_i),
    .timer_tick_o          (tick)
  );

  // bus handshake: exactly one wait cycle per access
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) avs_waitrequest_o <= 1'b1;
    else avs_waitrequest_o <= ~go;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_r <= CTRL_RST;
      ctrl_b_r <= CTRL_RST;
    end else begin
      if (wr_at(OFS_CTRL_A)) ctrl_a_r <= wbyte;
      if (wr_at(OFS_CTRL_B)) ctrl_b_r <= wbyte;
    end
  end

  // counting step; dual slope turns at top and at bottom
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_up_r;
    ovf_ev  = 1'b0;
    if (tick) begin
      unique case (kind)
        KIND_SINGLE, KIND_FAST: begin
          dir_nxt = 1'b1;
          if (cnt_r == top_val) cnt_nxt = VAL_BOTTOM;
          else cnt_nxt = cnt_r + VAL_ONE;
          if (kind == KIND_FAST) ovf_ev = (cnt_r == top_val);
          else ovf_ev = (cnt_r == VAL_MAX);
        end
        KIND_DUAL: begin
          if (dir_up_r && cnt_r >= top_val) begin
            dir_nxt = 1'b0;
            cnt_nxt = (cnt_r == VAL_BOTTOM) ? VAL_BOTTOM : cnt_r - VAL_ONE;
          end else if (!dir_up_r && cnt_r == VAL_BOTTOM) begin
            dir_nxt = 1'b1;
            cnt_nxt = cnt_r + VAL_ONE;
            ovf_ev  = 1'b1;
          end else if (dir_up_r) begin
            cnt_nxt = cnt_r + VAL_ONE;
          end else begin
            cnt_nxt = cnt_r - VAL_ONE;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
    // a software write wins over any step in the same cycle
    if (wr_at(OFS_CNT_L)) begin
      cnt_nxt = {temp_r, wbyte};
      ovf_ev  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= VAL_BOTTOM;
      dir_up_r <= 1'b1;
    end else begin
      cnt_r    <= cnt_nxt;
      dir_up_r <= dir_nxt;
    end
  end

  // high-byte locations all land in the one latch
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) temp_r <= 8'h00;
    else if (wr_at(OFS_CNT_H) || wr_at(OFS_CAP_H) ||
             wr_at(OFS_CMP_H[0]) || wr_at(OFS_CMP_H[1]) ||
             wr_at(OFS_CMP_H[2]))
      temp_r <= wbyte;
    else if (rd_at(OFS_CNT_L)) temp_r <= cnt_r[15:8];
    else if (rd_at(OFS_CAP_L)) temp_r <= cap_r[15:8];
  end

  // compare registers load directly; buffering belongs to waveform logic
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) cmp_r[i] <= VAL_BOTTOM;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_at(OFS_CMP_L[i])) cmp_r[i] <= {temp_r, wbyte};
      end
    end
  end

  // capture input is idle while capture defines top
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) cap_r <= VAL_BOTTOM;
    else if (wr_at(OFS_CAP_L) && icr_is_top(wgm))
      cap_r <= {temp_r, wbyte};
    else if (capture_strobe_i && !icr_is_top(wgm))
      cap_r <= cnt_r;
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_comb begin
    flags_set = 5'h00;
    flags_set[FLG_OVF] = ovf_ev;
    for (int i = 0; i < 3; i++) begin
      flags_set[FLG_CMP_LSB + i] = tick && (cnt_r == cmp_r[i]);
    end
    flags_set[FLG_CAP] = capture_strobe_i && !icr_is_top(wgm);
    flags_nxt = flags_r | flags_set;
    if (wr_at(OFS_FLAGS)) flags_nxt = (flags_r & ~wbyte[4:0]) | flags_set;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) flags_r <= 5'h00;
    else flags_r <= flags_nxt;
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (avs_address_i)
      OFS_CTRL_A: rd_byte = ctrl_a_r;
      OFS_CTRL_B: rd_byte = ctrl_b_r;
      OFS_CNT_L:  rd_byte = cnt_r[7:0];
      OFS_CNT_H:  rd_byte = temp_r;
      OFS_CAP_L:  rd_byte = cap_r[7:0];
      OFS_CAP_H:  rd_byte = temp_r;
      OFS_FLAGS:  rd_byte = {3'h0, flags_r};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (avs_address_i == OFS_CMP_L[i]) rd_byte = cmp_r[i][7:0];
          if (avs_address_i == OFS_CMP_H[i])
            rd_byte = cmp_r[i][15:8];
        end
      end
    endcase
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) avs_readdata_o <= 32'h0000_0000;
    else if (rd_go) avs_readdata_o <= {24'h00_0000, rd_byte};
  end

  // indications follow the counter value one to one
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      top_hit_o    <= 1'b0;
      bottom_hit_o <= 1'b1;
      max_hit_o    <= 1'b0;
    end else begin
      top_hit_o    <= (cnt_nxt == top_of(wgm, cmp_r[0], cap_r));
      bottom_hit_o <= (cnt_nxt == VAL_BOTTOM);
      max_hit_o    <= (cnt_nxt == VAL_MAX);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      count_value_o   <= VAL_BOTTOM;
      compare_a_o     <= VAL_BOTTOM;
      compare_b_o     <= VAL_BOTTOM;
      compare_c_o     <= VAL_BOTTOM;
      capture_value_o <= VAL_BOTTOM;
      overflow_flag_o <= 1'b0;
    end else begin
      count_value_o   <= cnt_nxt;
      compare_a_o     <= cmp_r[0];
      compare_b_o     <= cmp_r[1];
      compare_c_o     <= cmp_r[2];
      capture_value_o <= cap_r;
      overflow_flag_o <= flags_nxt[FLG_OVF];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  chk_bottom_flag: assert property (
    bottom_hit_o == (cnt_r == 16'h0000))
    else $error("bottom indication disagrees with counter");

  chk_max_flag: assert property (
    max_hit_o == (cnt_r == 16'hffff))
    else $error("max indication disagrees with counter");

  chk_ctc_clear_top: assert property (
    tick && wgm == 4'h4 && cnt_r == cmp_r[0] && !wr_at(OFS_CNT_L)
    |=> cnt_r == 16'h0000)
    else $error("counter did not clear at compare A top");

  chk_low_write_load: assert property (
    wr_at(OFS_CNT_L) |=> cnt_r == {$past(temp_r), $past(wbyte)})
    else $error("low byte write did not load full counter");

  chk_low_read_latch: assert property (
    rd_at(OFS_CNT_L) |=> {temp_r, 8'h00} == ($past(cnt_r) & 16'hff00))
    else $error("low byte read did not latch high byte");

  chk_cmp_hi_read: assert property (
    rd_at(OFS_CMP_H[0]) |=> avs_readdata_o[7:0] == compare_a_o[15:8]
    && $stable(temp_r))
    else $error("compare high read wrong or latch touched");

  chk_hi_write_latch: assert property (
    wr_at(OFS_CNT_H) && !tick |=> temp_r == $past(wbyte) && $stable(cnt_r))
    else $error("counter high write leaked past latch");

  chk_up_step: assert property (
    tick && wgm == 4'h0 && !wr_at(OFS_CNT_L)
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("normal mode did not step up by one");

  chk_stop_hold: assert property (
    cs == 3'h0 ##1 cs == 3'h0 && !wr_at(OFS_CNT_L) |=> $stable(cnt_r))
    else $error("stopped counter changed");

  chk_write_wins: assert property (
    wr_at(OFS_CNT_L) && tick |=> cnt_r == {$past(temp_r), $past(wbyte)})
    else $error("count step overrode software write");

  chk_ovf_sets: assert property (
    ovf_ev |=> flags_r[FLG_OVF] && overflow_flag_o)
    else $error("overflow event not flagged");

  chk_cap_guard: assert property (
    wr_at(OFS_CAP_L) && !icr_is_top(wgm) && !capture_strobe_i
    |=> $stable(cap_r))
    else $error("capture written outside capture-top mode");

  chk_one_wait: assert property (
    go |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not exactly one wait cycle");
endmodule

// File: tmr_cpu_model.sv
// Purpose: processor-side bus model, one byte access per command
// Assumes: slave answers by dropping waitrequest, any number of cycles
// Notes:   released lines show inverted values so stale data is not seen
module tmr_cpu_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic        be_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  output logic             read_o,
  output logic             write_o,
  output logic [5:0]       adr_o,
  output logic [31:0]      wdata_o,
  output logic [3:0]       be_o,
  output logic             done_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_o     <= 1'b0;
      write_o    <= 1'b0;
      adr_o      <= 6'h00;
      wdata_o    <= 32'h0;
      be_o       <= 4'h0;
      done_o     <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      done_o     <= 1'b0;
      rd_valid_o <= 1'b0;
      // one access in flight, nothing can slip between halves
      if (!(read_o || write_o) && go_i) begin
        read_o  <= !wr_i;
        write_o <= wr_i;
        adr_o   <= adr_i;
        wdata_o <= {24'h0, dat_i};
        be_o    <= {3'h0, be_i};
      end else if ((read_o || write_o) && !wait_i) begin
        read_o     <= 1'b0;
        write_o    <= 1'b0;
        adr_o      <= ~adr_o;
        wdata_o    <= ~wdata_o;
        be_o       <= ~be_o;
        done_o     <= 1'b1;
        rd_valid_o <= read_o;
        rd_data_o  <= rdata_i[7:0];
      end
    end
  end
endmodule

// File: tmr_pkg.sv
// Purpose: constants for the 16-bit timer/counter core
// Assumes: 32-bit avalon slave, byte data in lane 0
// Notes:   offsets are byte addresses, one word each
package tmr_pkg;
  localparam int unsigned AW = 6;
  localparam int unsigned CS_W = 3;
  localparam int unsigned WGM_W = 4;
  localparam logic [5:0] OFS_CTRL_A = 6'h00;
  localparam logic [5:0] OFS_CTRL_B = 6'h04;
  localparam logic [5:0] OFS_CNT_L = 6'h08;
  localparam logic [5:0] OFS_CNT_H = 6'h0c;
  localparam logic [5:0] OFS_CMP_L [3] = '{6'h10, 6'h18, 6'h20};
  localparam logic [5:0] OFS_CMP_H [3] = '{6'h14, 6'h1c, 6'h24};
  localparam logic [5:0] OFS_CAP_L = 6'h28;
  localparam logic [5:0] OFS_CAP_H = 6'h2c;
  localparam logic [5:0] OFS_FLAGS = 6'h30;
  localparam int unsigned CTA_WGM_LSB = 0;
  localparam int unsigned CTB_CS_LSB = 0;
  localparam int unsigned CTB_WGM_LSB = 3;
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMP_LSB = 1;
  localparam int unsigned FLG_CAP = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] VAL_BOTTOM = 16'h0000;
  localparam logic [15:0] VAL_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] VAL_ONE = 16'h0001;
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_OCR = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PFC_OCR = 4'h9;
  localparam logic [3:0] WGM_PC_ICR = 4'ha;
  localparam logic [3:0] WGM_PC_OCR = 4'hb;
  localparam logic [3:0] WGM_CTC_ICR = 4'hc;
  localparam logic [3:0] WGM_FAST_ICR = 4'he;
  localparam logic [3:0] WGM_FAST_OCR = 4'hf;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYS = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W = 10;
  typedef enum logic [1:0] {
    KIND_SINGLE = 2'b00,
    KIND_FAST   = 2'b01,
    KIND_DUAL   = 2'b11
  } tmr_kind_t;
endpackage

// File: tmr_tick_gen.sv
// Purpose: timer tick enable from the selected clock source
// Assumes: external pin is asynchronous to clk_sys_i
// Notes:   tick is registered, one cycle behind its cause
module tmr_tick_gen (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic [tmr_pkg::CS_W-1:0] clock_source_select_i,
  input  wire logic                    ext_clk_pin_i,
  output logic                         timer_tick_o
);
  import tmr_pkg::*;
  logic [PRESC_W-1:0] presc_r;
  logic [2:0]         ext_sync_r;
  logic               tick_nxt;

  // free running prescaler, shared by all divided rates
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) presc_r <= '0;
    else presc_r <= presc_r + 1'b1;
  end

  // stage 0 feeds stage 1 only; edges are seen on stages 1 and 2
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) ext_sync_r <= 3'h0;
    else ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin_i};
  end

  always_comb begin
    unique case (clock_source_select_i)
      CS_STOP:     tick_nxt = 1'b0;
      CS_SYS:      tick_nxt = 1'b1;
      CS_DIV8:     tick_nxt = &presc_r[2:0];
      CS_DIV64:    tick_nxt = &presc_r[5:0];
      CS_DIV256:   tick_nxt = &presc_r[7:0];
      CS_DIV1024:  tick_nxt = &presc_r[9:0];
      CS_EXT_FALL: tick_nxt = ext_sync_r[2] & ~ext_sync_r[1];
      CS_EXT_RISE: tick_nxt = ~ext_sync_r[2] & ext_sync_r[1];
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) timer_tick_o <= 1'b0;
    else timer_tick_o <= tick_nxt;
  end
endmodule
